// ==== common/wkf_pkg.sv ====
package wkf_pkg;
    // Register numbers within the wake page
    localparam logic [15:0] WKF_REG_ENABLE = 16'h0002;
    localparam logic [15:0] WKF_REG_STATUS = 16'h0003;
    localparam logic [15:0] WKF_REG_ADDR_LOW0 = 16'h0010;
    localparam logic [15:0] WKF_REG_ADDR_LOW1 = 16'h0011;
    localparam logic [15:0] WKF_REG_ADDR_HIGH0 = 16'h0012;
    localparam logic [15:0] WKF_REG_ADDR_HIGH1 = 16'h0013;
    // Management access: address-set and data register numbers
    localparam logic [4:0] WKF_MGMT_ADDR_SET = 5'h11;
    localparam logic [4:0] WKF_MGMT_DATA = 5'h12;
    // Enable register field positions
    localparam int WKF_EN_LINK = 0;
    localparam int WKF_EN_MAGIC = 1;
    localparam int WKF_EN_EXACT = 2;
    localparam int WKF_EN_MCAST = 3;
    localparam int WKF_EN_BCAST = 4;
    localparam int WKF_EN_ARP = 5;
    localparam int WKF_EN_IPV4 = 6;
    localparam int WKF_EN_IPV6 = 7;
    localparam int WKF_EN_RSVD = 8;
    localparam int WKF_EN_FLEX4 = 9;
    localparam int WKF_EN_FLEX5 = 10;
    localparam int WKF_EN_IGNORE_MGMT = 11;
    localparam int WKF_EN_FLEX0 = 12;
    // Station address high fields
    localparam int WKF_AV_BIT = 31;
    localparam logic [31:0] WKF_HIGH_WR_MASK = 32'h8003FFFF;
    // Reset values
    localparam logic [15:0] WKF_ENABLE_RST = 16'h0000;
    localparam logic [15:0] WKF_STATUS_RST = 16'h0000;
    localparam logic [31:0] WKF_ADDR_LOW_RST = 32'h00000000;
    localparam logic [31:0] WKF_ADDR_HIGH_RST = 32'h00000000;
    localparam logic [15:0] WKF_REGNUM_RST = 16'h0000;
endpackage

// ==== src/wkf_status_bit.sv ====
`timescale 1ns/100ps
`default_nettype none
// One sticky write-one-to-clear status bit; a hit beats a clear.
module wkf_status_bit (
    input wire logic clk,
    input wire logic por_b,
    input wire logic hit,
    input wire logic clear,
    output var logic flag
);
    always_ff @(posedge clk or negedge por_b) begin
        if (!por_b) begin
            flag <= 1'b0;
        end else if (hit) begin
            flag <= 1'b1;
        end else if (clear) begin
            flag <= 1'b0;
        end
    end
endmodule
`default_nettype wire

// ==== src/wkf_regs.sv ====
`timescale 1ns/100ps
`default_nettype none
module wkf_regs
    import wkf_pkg::*;
(
    input wire logic clk,
    input wire logic rst_b,
    input wire logic por_b,
    input wire logic mgmt_wr,
    input wire logic mgmt_rd,
    input wire logic [4:0] mgmt_reg,
    input wire logic [15:0] mgmt_wdata,
    output logic [15:0] mgmt_rdata,
    input wire logic link_change_evt,
    input wire logic magic_packet_evt,
    input wire logic pkt_valid,
    input wire logic [47:0] pkt_dest_addr,
    input wire logic [6:0] exact_match_other,
    input wire logic multicast_hash_hit,
    input wire logic broadcast_evt,
    input wire logic arp_request_evt,
    input wire logic ipv4_directed_evt,
    input wire logic ipv6_directed_evt,
    input wire logic [7:0] flex_match,
    input wire logic mgmt_packet_evt,
    input wire logic link_change_override,
    input wire logic apm_link_wake_en,
    input wire logic wake_status_clear,
    output logic wake_status_indication,
    output logic host_wake_event,
    output logic [31:0] exact_addr_low,
    output logic [15:0] exact_addr_high,
    output logic address_valid
);
    logic [15:0] target_register_number;
    logic [15:0] wake_filter_enable;
    logic [15:0] wake_event_status;
    logic [31:0] station_addr_low;
    logic [31:0] station_addr_high;
    logic [15:0] hit;
    logic [15:0] clr;
    logic [15:0] filt_en;
    logic own_exact;
    logic link_en;
    logic any_hit;
    logic data_wr;
    logic [15:0] sel_reg;

    assign data_wr = mgmt_wr && (mgmt_reg == WKF_MGMT_DATA);
    assign sel_reg = target_register_number;

    // Register number latch for the indirect data window
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            target_register_number <= WKF_REGNUM_RST;
        end else if (mgmt_wr && mgmt_reg == WKF_MGMT_ADDR_SET) begin
            target_register_number <= mgmt_wdata;
        end
    end

    // Filter enables; reserved bit 8 never stores, so it reads zero.
    // Wake registers sit on power-on reset so PHY reset leaves them.
    always_ff @(posedge clk or negedge por_b) begin
        if (!por_b) begin
            wake_filter_enable <= WKF_ENABLE_RST;
        end else if (data_wr && sel_reg == WKF_REG_ENABLE) begin
            wake_filter_enable <= mgmt_wdata;
            wake_filter_enable[WKF_EN_RSVD] <= 1'b0;
        end
    end

    // Station address words, written one 16-bit half at a time
    always_ff @(posedge clk or negedge por_b) begin
        if (!por_b) begin
            station_addr_low <= WKF_ADDR_LOW_RST;
            station_addr_high <= WKF_ADDR_HIGH_RST;
        end else if (data_wr) begin
            if (sel_reg == WKF_REG_ADDR_LOW0) begin
                station_addr_low[15:0] <= mgmt_wdata;
            end
            if (sel_reg == WKF_REG_ADDR_LOW1) begin
                station_addr_low[31:16] <= mgmt_wdata;
            end
            if (sel_reg == WKF_REG_ADDR_HIGH0) begin
                station_addr_high[15:0] <= mgmt_wdata;
            end
            if (sel_reg == WKF_REG_ADDR_HIGH1) begin
                // Upper half keeps only bits 17:16 and the valid bit
                station_addr_high[31:16] <=
                    mgmt_wdata & WKF_HIGH_WR_MASK[31:16];
            end
        end
    end

    assign exact_addr_low = station_addr_low;
    assign exact_addr_high = station_addr_high[15:0];
    assign address_valid = station_addr_high[WKF_AV_BIT];

    // Own entry matches only while marked valid
    assign own_exact = address_valid && pkt_valid &&
        (pkt_dest_addr == {station_addr_high[15:0], station_addr_low});

    // Link wake follows power management when overridden
    assign link_en = link_change_override ? apm_link_wake_en
        : wake_filter_enable[WKF_EN_LINK];

    // Effective enables in status bit order
    always_comb begin
        filt_en = 16'h0000;
        filt_en[0] = link_en;
        filt_en[1] = wake_filter_enable[WKF_EN_MAGIC];
        filt_en[2] = wake_filter_enable[WKF_EN_EXACT];
        filt_en[3] = wake_filter_enable[WKF_EN_MCAST];
        filt_en[4] = wake_filter_enable[WKF_EN_BCAST];
        filt_en[5] = wake_filter_enable[WKF_EN_ARP];
        filt_en[6] = wake_filter_enable[WKF_EN_IPV4];
        filt_en[7] = wake_filter_enable[WKF_EN_IPV6];
        filt_en[8] = wake_filter_enable[WKF_EN_FLEX4];
        filt_en[9] = wake_filter_enable[WKF_EN_FLEX5];
        // Flex 6 and 7 enables live in the wake control register
        filt_en[10] = 1'b1;
        filt_en[11] = 1'b1;
        filt_en[15:12] = wake_filter_enable[15:WKF_EN_FLEX0];
    end

    // Raw matches, gated by enables and the manageability block.
    // All bits are evaluated in parallel so one packet sets several.
    always_comb begin
        hit = 16'h0000;
        hit[0] = link_change_evt;
        hit[1] = magic_packet_evt;
        hit[2] = own_exact || (pkt_valid && |exact_match_other);
        hit[3] = pkt_valid && multicast_hash_hit;
        hit[4] = broadcast_evt;
        hit[5] = arp_request_evt;
        hit[6] = ipv4_directed_evt;
        hit[7] = ipv6_directed_evt;
        hit[11:8] = flex_match[7:4];
        hit[15:12] = flex_match[3:0];
        hit = hit & filt_en;
        if (wake_filter_enable[WKF_EN_IGNORE_MGMT] && mgmt_packet_evt) begin
            hit[15:1] = 15'h0000;
        end
    end

    assign clr = (data_wr && sel_reg == WKF_REG_STATUS) ? mgmt_wdata
        : 16'h0000;
    assign any_hit = |hit;

    // Sticky status bits on power-on reset only
    for (genvar i = 0; i < 16; i++) begin : g_status
        wkf_status_bit u_bit (
            .clk(clk),
            .por_b(por_b),
            .hit(hit[i]),
            .clear(clr[i]),
            .flag(wake_event_status[i])
        );
    end

    // Wake status indication; an event beats a simultaneous clear
    always_ff @(posedge clk or negedge por_b) begin
        if (!por_b) begin
            wake_status_indication <= 1'b0;
        end else if (any_hit) begin
            wake_status_indication <= 1'b1;
        end else if (wake_status_clear) begin
            wake_status_indication <= 1'b0;
        end
    end

    // Wake pulse for the power controller: any_hit registered, as long as any_hit lasts
    always_ff @(posedge clk or negedge por_b) begin
        if (!por_b) begin
            host_wake_event <= 1'b0;
        end else begin
            host_wake_event <= any_hit;
        end
    end

    // Read data registered one cycle after the read strobe
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            mgmt_rdata <= 16'h0000;
        end else if (mgmt_rd) begin
            mgmt_rdata <= 16'h0000;
            if (mgmt_reg == WKF_MGMT_ADDR_SET) begin
                mgmt_rdata <= target_register_number;
            end else if (mgmt_reg == WKF_MGMT_DATA) begin
                unique case (sel_reg)
                    WKF_REG_ENABLE: mgmt_rdata <= wake_filter_enable;
                    WKF_REG_STATUS: mgmt_rdata <= wake_event_status;
                    WKF_REG_ADDR_LOW0: mgmt_rdata <= station_addr_low[15:0];
                    WKF_REG_ADDR_LOW1: mgmt_rdata <= station_addr_low[31:16];
                    WKF_REG_ADDR_HIGH0: mgmt_rdata <= station_addr_high[15:0];
                    WKF_REG_ADDR_HIGH1: mgmt_rdata <= station_addr_high[31:16];
                    default: mgmt_rdata <= 16'h0000;
                endcase
            end
        end
    end

    // Status set by an enabled event, at the next edge
    status_set_a: assert property (
        @(posedge clk) disable iff (!por_b)
        hit[4] |=> wake_event_status[4])
        else $error("broadcast status not set");
    // Disabled filter never sets status
    disabled_quiet_a: assert property (
        @(posedge clk) disable iff (!por_b)
        !wake_event_status[1] && !wake_filter_enable[WKF_EN_MAGIC]
        |=> !wake_event_status[1])
        else $error("status set with filter off");
    // Write one clears only the written bit
    w1c_clear_a: assert property (
        @(posedge clk) disable iff (!por_b)
        clr[3] && !hit[3] |=> !wake_event_status[3])
        else $error("status bit not cleared");
    w1c_keep_a: assert property (
        @(posedge clk) disable iff (!por_b)
        data_wr && sel_reg == WKF_REG_STATUS && !mgmt_wdata[5] &&
        wake_event_status[5] |=> wake_event_status[5])
        else $error("unwritten status bit lost");
    // Reserved enable bit stays zero
    rsvd_zero_a: assert property (
        @(posedge clk) disable iff (!por_b)
        !wake_filter_enable[WKF_EN_RSVD])
        else $error("reserved enable bit set");
    // High register reserved field reads zero
    high_rsvd_a: assert property (
        @(posedge clk) disable iff (!por_b)
        station_addr_high[30:18] == 13'h0000)
        else $error("reserved address bits set");
    // With the ignore bit set, manageability packets wake the host only through link change
    mgmt_block_a: assert property (
        @(posedge clk) disable iff (!por_b)
        wake_filter_enable[WKF_EN_IGNORE_MGMT] && mgmt_packet_evt &&
        !link_change_evt |=> !host_wake_event)
        else $error("wake from manageability packet");
    // Any wake sets the indication
    wake_ind_a: assert property (
        @(posedge clk) disable iff (!por_b)
        host_wake_event |-> wake_status_indication)
        else $error("wake without indication");
    // Invalid address never matches
    av_gate_a: assert property (
        @(posedge clk) disable iff (!por_b)
        !address_valid |-> !own_exact)
        else $error("match on invalid address");
    // Written flex 0 enable bit reads back
    en_write_a: assert property (
        @(posedge clk) disable iff (!por_b)
        data_wr && sel_reg == WKF_REG_ENABLE |=>
        wake_filter_enable[WKF_EN_FLEX0] == $past(mgmt_wdata[12]))
        else $error("enable write lost");
    // Enabled event gives the pulse and the indication a cycle later
    wake_pulse_a: assert property (
        @(posedge clk) disable iff (!por_b)
        any_hit |=> host_wake_event && wake_status_indication)
        else $error("event without wake pulse");
    // No enabled event, no pulse: the power controller must not glitch
    quiet_pulse_a: assert property (
        @(posedge clk) disable iff (!por_b)
        !any_hit |=> !host_wake_event)
        else $error("wake pulse without event");
    // Under override the power-management enable alone gates link wake
    link_ovr_a: assert property (
        @(posedge clk) disable iff (!por_b)
        link_change_override && apm_link_wake_en && link_change_evt
        |=> wake_event_status[0])
        else $error("overridden link wake lost");
    // Valid bit follows the top bit written to the upper half
    av_write_a: assert property (
        @(posedge clk) disable iff (!por_b)
        data_wr && sel_reg == WKF_REG_ADDR_HIGH1 |=>
        address_valid == $past(mgmt_wdata[15]))
        else $error("address valid write lost");
    // Own valid address sets the exact bit while that filter is on
    exact_set_a: assert property (
        @(posedge clk) disable iff (!por_b)
        own_exact && filt_en[2] && !mgmt_packet_evt |=>
        wake_event_status[2])
        else $error("exact match not recorded");
    // Flexible filter 4 is enabled by bit 9 and lands on status bit 8
    flex_map_a: assert property (
        @(posedge clk) disable iff (!por_b)
        flex_match[4] && wake_filter_enable[WKF_EN_FLEX4] &&
        !mgmt_packet_evt |=> wake_event_status[8])
        else $error("flex 4 match not recorded");
endmodule
`default_nettype wire

// ==== dv/wkf_host_model.sv ====
`timescale 1ns/100ps
`default_nettype none
// Host driver on the management side, already on the wake page
module wkf_host_model (
    input wire logic clk,
    output logic mgmt_wr,
    output logic mgmt_rd,
    output logic [4:0] mgmt_reg,
    output logic [15:0] mgmt_wdata,
    input wire logic [15:0] mgmt_rdata
);
    initial begin
        mgmt_wr = 1'b0;
        mgmt_rd = 1'b0;
        mgmt_reg = 5'h00;
        mgmt_wdata = 16'h0000;
    end
    // Address set, then data cycle; one-cycle strobes back to back
    task automatic wr(input logic [15:0] n, input logic [15:0] d);
        @(posedge clk);
        mgmt_wr <= 1'b1;
        mgmt_reg <= 5'h11;
        mgmt_wdata <= n;
        @(posedge clk);
        mgmt_reg <= 5'h12;
        mgmt_wdata <= d;
        @(posedge clk);
        mgmt_wr <= 1'b0;
        mgmt_wdata <= ~d;
    endtask
    // Read data is registered, so it is taken one edge after the strobe
    task automatic rd(input logic [15:0] n, output logic [15:0] d);
        @(posedge clk);
        mgmt_wr <= 1'b1;
        mgmt_wdata <= n;
        mgmt_reg <= 5'h11;
        @(posedge clk);
        mgmt_wr <= 1'b0;
        mgmt_rd <= 1'b1;
        mgmt_reg <= 5'h12;
        @(posedge clk);
        mgmt_rd <= 1'b0;
        @(posedge clk);
        d = mgmt_rdata;
    endtask
endmodule
`default_nettype wire

// ==== dv/tb.sv ====
`timescale 1ns/100ps
`default_nettype none
module tb;
    import wkf_pkg::*;
    logic clk = 0, rst_b = 0, por_b = 0;
    logic mgmt_wr, mgmt_rd;
    logic [4:0] mgmt_reg;
    logic [15:0] mgmt_wdata, mgmt_rdata;
    logic link = 0, magic_packet_wake = 0, bc = 0, arp = 0, v4 = 0, v6 = 0;
    logic pkt_valid = 0, mc_hit = 0, mpkt = 0, ovr = 0, apm = 0, wclr = 0;
    logic [6:0] exo = 0;
    logic [7:0] flx = 0;
    logic [47:0] dst = 0;
    logic ind, wake, av;
    logic [31:0] alow;
    logic [15:0] ahigh;
    int n_errors = 0, checks = 0, n_wake = 0, n0;

    wkf_host_model i_host (.clk(clk), .mgmt_wr(mgmt_wr), .mgmt_rd(mgmt_rd),
        .mgmt_reg(mgmt_reg), .mgmt_wdata(mgmt_wdata),
        .mgmt_rdata(mgmt_rdata));
    wkf_regs i_dut (.clk(clk), .rst_b(rst_b), .por_b(por_b),
        .mgmt_wr(mgmt_wr), .mgmt_rd(mgmt_rd), .mgmt_reg(mgmt_reg),
        .mgmt_wdata(mgmt_wdata), .mgmt_rdata(mgmt_rdata),
        .link_change_evt(link), .magic_packet_evt(magic_packet_wake),
        .pkt_valid(pkt_valid), .pkt_dest_addr(dst),
        .exact_match_other(exo), .multicast_hash_hit(mc_hit),
        .broadcast_evt(bc), .arp_request_evt(arp),
        .ipv4_directed_evt(v4), .ipv6_directed_evt(v6), .flex_match(flx),
        .mgmt_packet_evt(mpkt), .link_change_override(ovr),
        .apm_link_wake_en(apm), .wake_status_clear(wclr),
        .wake_status_indication(ind), .host_wake_event(wake),
        .exact_addr_low(alow), .exact_addr_high(ahigh),
        .address_valid(av));

    always #4 clk = ~clk;
    // Wake pulses last one cycle, so count them at every edge
    always @(posedge clk) n_wake += (wake === 1'b1);

    task automatic test_done;
        $display("checks=%0d n_errors=%0d", checks, n_errors);
        if (n_errors == 0 && checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            n_errors++;
            $display("unexpected at %0t: got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic rchk(input logic [15:0] n, input logic [15:0] exp);
        logic [15:0] d;
        i_host.rd(n, d);
        chk({16'h0000, d}, {16'h0000, exp});
    endtask
    // One packet worth of matches, laid out like the status bits
    task automatic pulse(input logic [15:0] m);
        @(posedge clk);
        {link, magic_packet_wake, mc_hit, bc} <= {m[0], m[1], m[3], m[4]};
        {v6, v4, arp, pkt_valid} <= {m[7:5], 1'b1};
        exo <= {6'h00, m[2]};
        flx <= {m[11:8], m[15:12]};
        @(posedge clk);
        {link, magic_packet_wake, mc_hit, bc, arp, v4, v6, pkt_valid} <= 8'h00;
        exo <= 7'h00;
        flx <= 8'h00;
        repeat (2) @(posedge clk);
    endtask

    task automatic t_reset;
        rchk(WKF_REG_ENABLE, 16'h0000);
        rchk(WKF_REG_STATUS, 16'h0000);
        rchk(WKF_REG_ADDR_LOW0, 16'h0000);
        rchk(WKF_REG_ADDR_HIGH1, 16'h0000);
        rchk(16'h0005, 16'h0000);
    endtask
    task automatic t_enable;
        i_host.wr(WKF_REG_ENABLE, 16'hFFFF);
        rchk(WKF_REG_ENABLE, 16'hFEFF);
        i_host.wr(WKF_REG_ENABLE, 16'h0000);
        rchk(WKF_REG_ENABLE, 16'h0000);
    endtask
    task automatic t_status;
        i_host.wr(WKF_REG_ENABLE, 16'hF6FF);
        n0 = n_wake;
        pulse(16'hFFFF);
        rchk(WKF_REG_STATUS, 16'hFFFF);
        chk(n_wake - n0, 1);
        chk(ind, 1);
        i_host.wr(WKF_REG_STATUS, 16'h0010);
        rchk(WKF_REG_STATUS, 16'hFFEF);
        @(posedge clk) rst_b <= 1'b0;
        @(posedge clk) rst_b <= 1'b1;
        rchk(WKF_REG_STATUS, 16'hFFEF);
        @(posedge clk) wclr <= 1'b1;
        @(posedge clk) wclr <= 1'b0;
        @(posedge clk) chk(ind, 0);
        por_b <= 1'b0;
        @(posedge clk) por_b <= 1'b1;
        rchk(WKF_REG_STATUS, 16'h0000);
        rchk(WKF_REG_ENABLE, 16'h0000);
    endtask
    // One source at a time must land on its own status bit
    task automatic t_map;
        i_host.wr(WKF_REG_ENABLE, 16'hF6FF);
        for (int i = 0; i < 16; i++) begin
            pulse(16'h0001 << i);
            rchk(WKF_REG_STATUS, 16'h0001 << i);
            i_host.wr(WKF_REG_STATUS, 16'hFFFF);
        end
    endtask
    // Disabled filters stay silent, flex 4 and 5 not driven; link enabled, and flex 6 and 7 always on
    task automatic t_disabled;
        i_host.wr(WKF_REG_ENABLE, 16'h0001);
        pulse(16'hF0FE);
        rchk(WKF_REG_STATUS, 16'h0000);
        pulse(16'h0001);
        rchk(WKF_REG_STATUS, 16'h0001);
        i_host.wr(WKF_REG_STATUS, 16'hFFFF);
    endtask
    task automatic t_ignore;
        i_host.wr(WKF_REG_ENABLE, 16'h0802);
        mpkt <= 1'b1;
        n0 = n_wake;
        pulse(16'h0002);
        chk(n_wake - n0, 0);
        mpkt <= 1'b0;
        pulse(16'h0002);
        chk(n_wake - n0, 1);
    endtask
    // Link wake follows the power-management enable under override
    task automatic t_override;
        i_host.wr(WKF_REG_ENABLE, 16'h0000);
        {ovr, apm} <= 2'b11;
        n0 = n_wake;
        pulse(16'h0001);
        chk(n_wake - n0, 1);
        apm <= 1'b0;
        pulse(16'h0001);
        chk(n_wake - n0, 1);
        ovr <= 1'b0;
    endtask
    task automatic t_addr;
        i_host.wr(WKF_REG_ADDR_LOW0, 16'h3344);
        i_host.wr(WKF_REG_ADDR_LOW1, 16'h1122);
        i_host.wr(WKF_REG_ADDR_HIGH0, 16'h5566);
        i_host.wr(WKF_REG_ADDR_HIGH1, 16'hFFFF);
        rchk(WKF_REG_ADDR_HIGH1, 16'h8003);
        chk(alow, 32'h11223344);
        chk({16'h0000, ahigh}, 32'h00005566);
        chk(av, 1);
        i_host.wr(WKF_REG_ENABLE, 16'h0004);
        i_host.wr(WKF_REG_STATUS, 16'hFFFF);
        dst <= 48'h5566_1122_3344;
        pulse(16'h0000);
        rchk(WKF_REG_STATUS, 16'h0004);
        i_host.wr(WKF_REG_ADDR_HIGH1, 16'h0003);
        i_host.wr(WKF_REG_STATUS, 16'hFFFF);
        pulse(16'h0000);
        rchk(WKF_REG_STATUS, 16'h0000);
    endtask

    // Run is a few hundred cycles; the limit leaves wide margin
    initial begin
        #200000;
        n_errors++;
        test_done;
    end
    initial begin
        repeat (3) @(posedge clk);
        rst_b <= 1'b1;
        por_b <= 1'b1;
        t_reset;
        t_enable;
        t_status;
        t_map;
        t_disabled;
        t_ignore;
        t_override;
        t_addr;
        test_done;
    end
endmodule
`default_nettype wire
